// ===== pkg/prbs_params.svh
`ifndef PRBS_PARAMS_SVH
`define PRBS_PARAMS_SVH
`define PRBS_ADDR_W        12
`define PRBS_IDX_CTRL      8'h71
`define PRBS_IDX_STAT      8'h72
`define PRBS_IDX_FLAGS     8'h73
`define PRBS_CTRL_RESET    4'h0
`define PRBS_BIT_RX_INV    3
`define PRBS_BIT_TX_INV    2
`define PRBS_BIT_BERR_EN   3
`define PRBS_BIT_INJ       2
`define PRBS_BIT_LOCKED    1
`define PRBS_BIT_LOCK_EN   0
`define PRBS_BIT_BERR_FLAG 3
`define PRBS_BIT_LOCK_FLAG 0
`define PRBS_WINDOW_BITS   6'd48
`define PRBS_LOSS_ERRORS   4'd10
`define PRBS_LOCK_BITS     6'd48
`define PRBS_LFSR_W        20
`endif

// ===== pkg/prbs_pkg.sv
package prbs_pkg;
   typedef enum logic [1:0] {
      PAT_15 = 2'b00,
      PAT_20 = 2'b01,
      PAT_11 = 2'b10,
      PAT_RSV = 2'b11
   } pattern_e;

   typedef logic [19:0] lfsr_t;

   typedef struct packed {
      lfsr_t lfsr;
   } lfsr_state_s;

   typedef struct packed {
      logic       rx_invert;
      logic       tx_invert;
      pattern_e   pattern_select;
      logic       bit_error_irq_enable;
      logic       single_error_inject;
      logic       pattern_locked_status;
      logic       lock_change_irq_enable;
      logic       bit_error_flag;
      logic       lock_change_flag;
      logic [5:0] win_cnt;
      logic [3:0] err_cnt;
      logic [5:0] run_cnt;
      logic       tx_bit;
      logic       tx_valid;
      logic [7:0] rdata;
   } top_state_s;
endpackage

// ===== pkg/prbs_lfsr_if.sv
`timescale 1ns/10ps
interface prbs_lfsr_if;
   logic                 step;     // Advance one bit.
   logic                 load_en;  // Shift in load_bit instead of feedback.
   logic                 load_bit; // Bit shifted in when load_en is high.
   prbs_pkg::pattern_e   sel;      // Pattern polynomial choice.
   logic                 fb;       // Next pattern bit.
   modport ctl  (output step, output load_en, output load_bit, output sel, input fb);
   modport core (input step, input load_en, input load_bit, input sel, output fb);
endinterface // prbs_lfsr_if

// ===== hdl/prbs_lfsr.sv
`timescale 1ns/10ps
`include "prbs_params.svh"
module prbs_lfsr (
   input wire logic     pclk,    // Bit-side clock.
   input wire logic     presetn, // Asynchronous reset, active low.
   prbs_lfsr_if.core    lf       // Control and feedback.
);
   prbs_pkg::lfsr_state_s st_ff;
   prbs_pkg::lfsr_state_s nxt_st;

   // Feedback taps per pattern; the reserved code falls back to the 15-bit sequence.
   function automatic logic feedback(input prbs_pkg::lfsr_t s, input prbs_pkg::pattern_e p);
      unique case (p)
         prbs_pkg::PAT_20: feedback = s[19] ^ s[16];
         prbs_pkg::PAT_11: feedback = s[10] ^ s[8];
         prbs_pkg::PAT_15,
         prbs_pkg::PAT_RSV: feedback = s[14] ^ s[13];
      endcase
   endfunction

   // An all-zero register would lock up, so a one is forced in.
   always_comb begin
      nxt_st = st_ff;
      lf.fb = feedback(st_ff.lfsr, lf.sel);
      if (lf.step) begin
         if (lf.load_en) begin
            nxt_st.lfsr = {st_ff.lfsr[18:0], lf.load_bit};
         end else if (st_ff.lfsr == 20'h00000) begin
            nxt_st.lfsr = 20'h00001;
         end else begin
            nxt_st.lfsr = {st_ff.lfsr[18:0], lf.fb};
         end
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{lfsr: 20'h00001};
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule // prbs_lfsr

// ===== hdl/pattern_gen_detector.sv
`timescale 1ns/10ps
`include "prbs_params.svh"
module pattern_gen_detector (
   input  wire logic                    pclk,        // 50 MHz clock.
   input  wire logic                    presetn,     // Asynchronous reset, active low.
   input  wire logic                    psel,        // APB select.
   input  wire logic                    penable,     // APB access phase.
   input  wire logic                    pwrite,      // APB write.
   input  wire logic [`PRBS_ADDR_W-1:0] paddr,       // APB byte address.
   input  wire logic [31:0]             pwdata,      // APB write data.
   output      logic [31:0]             prdata,      // APB read data.
   output      logic                    pready,      // APB ready.
   output      logic                    pslverr,     // APB error on unmapped address.
   input  wire logic                    tx_bit_req,  // Framer wants one transmit bit.
   output      logic                    tx_bit,      // Transmit pattern bit.
   output      logic                    tx_bit_valid,// Pulse: tx_bit is new.
   input  wire logic                    rx_bit_valid,// Pulse: rx_bit carries a bit.
   input  wire logic                    rx_bit,      // Extracted receive bit.
   output      logic                    irq          // Level interrupt, active high.
);
   prbs_pkg::top_state_s st_ff;
   prbs_pkg::top_state_s nxt_st;

   prbs_lfsr_if gen_if ();
   prbs_lfsr_if det_if ();

   prbs_lfsr u_gen (
      .pclk    (pclk),
      .presetn (presetn),
      .lf      (gen_if.core)
   );

   prbs_lfsr u_det (
      .pclk    (pclk),
      .presetn (presetn),
      .lf      (det_if.core)
   );

   // Register index to byte address: the printed offsets are word indices.
   function automatic logic [`PRBS_ADDR_W-1:0] addr_of(input logic [7:0] idx);
      addr_of = {2'b00, idx, 2'b00};
   endfunction

   // Read view of the control register.
   // Reserved bits read as zero so that software can mask nothing and still compare.
   function automatic logic [7:0] ctrl_view(input prbs_pkg::top_state_s s);
      ctrl_view                   = 8'h00;
      ctrl_view[`PRBS_BIT_RX_INV] = s.rx_invert;
      ctrl_view[`PRBS_BIT_TX_INV] = s.tx_invert;
      ctrl_view[1:0]              = s.pattern_select;
   endfunction

   // Read view of the status and error-control register.
   // The lock bit is a live status; writes to its position are ignored.
   function automatic logic [7:0] stat_view(input prbs_pkg::top_state_s s);
      stat_view                    = 8'h00;
      stat_view[`PRBS_BIT_BERR_EN] = s.bit_error_irq_enable;
      stat_view[`PRBS_BIT_INJ]     = s.single_error_inject;
      stat_view[`PRBS_BIT_LOCKED]  = s.pattern_locked_status;
      stat_view[`PRBS_BIT_LOCK_EN] = s.lock_change_irq_enable;
   endfunction

   // Read view of the event flag register.
   // Reading does not clear anything; only a write of one does.
   function automatic logic [7:0] flag_view(input prbs_pkg::top_state_s s);
      flag_view                      = 8'h00;
      flag_view[`PRBS_BIT_BERR_FLAG] = s.bit_error_flag;
      flag_view[`PRBS_BIT_LOCK_FLAG] = s.lock_change_flag;
   endfunction

   // How the detector works, for whoever changes it next.
   // While unlocked, the detector register is filled from the received bits
   // themselves, so it needs no knowledge of the transmitter's phase.
   // Once the register holds enough history, its prediction matches every
   // new bit, and a run of error-free bits builds up towards lock.
   // While locked, the register runs free on its own feedback, so a single
   // corrupted bit shows as one error and does not poison later predictions.
   // Loss of lock uses a fixed window that restarts every 48 bits; errors
   // that straddle two windows are therefore split between them.
   // That is a deliberate trade: a sliding window would need 48 bits of
   // history and a population count, for little practical gain.
   // The run counter only counts while unlocked and the window counters only
   // while locked; each is cleared when the other side takes over.
   // The reserved select code behaves as the 15-bit sequence, so a stray
   // write never leaves the engines without a polynomial.
   //
   // Transmit side notes.
   // Each request from the framer produces exactly one new bit a cycle
   // later; there is no buffer, so the framer must not expect bits it has
   // not asked for.
   // A pending error insertion is consumed by the next request, so with no
   // requests the inject bit stays set and reads back as one.
   //
   // Bus side notes.
   // The slave answers with no wait state; read data is loaded at the setup
   // edge so that it comes from a flip-flop during the access phase.
   // Unmapped addresses answer with an error and read as zero.

   logic       acc_wr;
   logic       hit_ctrl;
   logic       hit_stat;
   logic       hit_flags;
   logic       mapped;
   logic       rx_d;
   logic       bit_err;
   logic [7:0] wbyte;

   // Address decode and data-path helpers.
   always_comb begin
      hit_ctrl  = (paddr == addr_of(`PRBS_IDX_CTRL));
      hit_stat  = (paddr == addr_of(`PRBS_IDX_STAT));
      hit_flags = (paddr == addr_of(`PRBS_IDX_FLAGS));
      mapped    = hit_ctrl | hit_stat | hit_flags;
      acc_wr    = psel & penable & pwrite;
      wbyte     = pwdata[7:0];
      rx_d      = rx_bit ^ st_ff.rx_invert;
      bit_err   = rx_d ^ det_if.fb;
   end

   // Both pattern engines follow the same select field.
   assign gen_if.sel      = st_ff.pattern_select;
   assign gen_if.step     = tx_bit_req;
   assign gen_if.load_en  = 1'b0;
   assign gen_if.load_bit = 1'b0;
   assign det_if.sel      = st_ff.pattern_select;
   assign det_if.step     = rx_bit_valid;
   assign det_if.load_en  = ~st_ff.pattern_locked_status;
   assign det_if.load_bit = rx_d;

   // Next-state logic: bus writes first, then hardware events, then the inject write, so that a set wins.
   always_comb begin
      logic       lock_next;
      logic [5:0] win_n;
      logic [3:0] err_n;
      lock_next = st_ff.pattern_locked_status;
      win_n     = st_ff.win_cnt;
      err_n     = st_ff.err_cnt;
      nxt_st          = st_ff;
      nxt_st.tx_valid = 1'b0;

      if (acc_wr && hit_ctrl) begin
         nxt_st.rx_invert      = wbyte[`PRBS_BIT_RX_INV];
         nxt_st.tx_invert      = wbyte[`PRBS_BIT_TX_INV];
         nxt_st.pattern_select = prbs_pkg::pattern_e'(wbyte[1:0]);
      end
      if (acc_wr && hit_stat) begin
         nxt_st.bit_error_irq_enable   = wbyte[`PRBS_BIT_BERR_EN];
         nxt_st.lock_change_irq_enable = wbyte[`PRBS_BIT_LOCK_EN];
      end
      // Write one clears; write zero leaves the flag alone.
      if (acc_wr && hit_flags) begin
         if (wbyte[`PRBS_BIT_BERR_FLAG]) begin
            nxt_st.bit_error_flag = 1'b0;
         end
         if (wbyte[`PRBS_BIT_LOCK_FLAG]) begin
            nxt_st.lock_change_flag = 1'b0;
         end
      end

      // Transmit: one bit per request, inverted and optionally corrupted once.
      if (tx_bit_req) begin
         nxt_st.tx_valid = 1'b1;
         nxt_st.tx_bit   = gen_if.fb ^ st_ff.tx_invert ^ st_ff.single_error_inject;
         if (st_ff.single_error_inject) begin
            nxt_st.single_error_inject = 1'b0;
         end
      end
      // A fresh insertion written in the same cycle as a request survives.
      if (acc_wr && hit_stat && wbyte[`PRBS_BIT_INJ]) begin
         nxt_st.single_error_inject = 1'b1;
      end

      // Detector: lock tracking on each received bit.
      if (rx_bit_valid) begin
         if (st_ff.pattern_locked_status) begin
            if (bit_err) begin
               nxt_st.bit_error_flag = 1'b1;
               err_n = st_ff.err_cnt + 4'd1;
            end
            win_n = st_ff.win_cnt + 6'd1;
            if (err_n >= `PRBS_LOSS_ERRORS) begin
               lock_next = 1'b0;
               win_n     = 6'd0;
               err_n     = 4'd0;
            end else if (win_n == `PRBS_WINDOW_BITS) begin
               win_n = 6'd0;
               err_n = 4'd0;
            end
            nxt_st.run_cnt = 6'd0;
         end else begin
            if (bit_err) begin
               nxt_st.run_cnt = 6'd0;
            end else if (st_ff.run_cnt + 6'd1 == `PRBS_LOCK_BITS) begin
               lock_next      = 1'b1;
               nxt_st.run_cnt = 6'd0;
               win_n          = 6'd0;
               err_n          = 4'd0;
            end else begin
               nxt_st.run_cnt = st_ff.run_cnt + 6'd1;
            end
         end
      end
      nxt_st.win_cnt               = win_n;
      nxt_st.err_cnt               = err_n;
      nxt_st.pattern_locked_status = lock_next;
      if (lock_next != st_ff.pattern_locked_status) begin
         nxt_st.lock_change_flag = 1'b1;
      end

      // Read data is captured in the setup phase so it comes from a flip-flop.
      if (psel && !penable && !pwrite) begin
         nxt_st.rdata = 8'h00;
         // The views read the current state, so a flag set in this very
         // cycle shows up on the next read, never half-way through one.
         if (hit_ctrl) begin
            nxt_st.rdata = ctrl_view(st_ff);
         end else if (hit_stat) begin
            nxt_st.rdata = stat_view(st_ff);
         end else if (hit_flags) begin
            nxt_st.rdata = flag_view(st_ff);
         end
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Zero-wait slave: every access completes in its first access cycle.
   assign pready       = 1'b1;
   assign pslverr      = psel & penable & ~mapped;
   assign prdata       = {24'h000000, st_ff.rdata};
   assign tx_bit       = st_ff.tx_bit;
   assign tx_bit_valid = st_ff.tx_valid;

   // Each flag reaches the interrupt only through its own enable.
   assign irq = (st_ff.bit_error_flag & st_ff.bit_error_irq_enable)
              | (st_ff.lock_change_flag & st_ff.lock_change_irq_enable);
endmodule // pattern_gen_detector

// ===== test/pattern_gen_detector_chk.sv
`timescale 1ns/10ps
module pattern_gen_detector_chk (
   input wire logic        pclk,         // Clock.
   input wire logic        presetn,      // Reset, active low.
   input wire logic        psel,         // Select.
   input wire logic        penable,      // Access phase.
   input wire logic        pwrite,       // Write.
   input wire logic [11:0] paddr,        // Byte address.
   input wire logic [31:0] prdata,       // Read data.
   input wire logic        pready,       // Ready.
   input wire logic        pslverr,      // Error.
   input wire logic        tx_bit_req,   // Bit request.
   input wire logic        tx_bit,       // Bit out.
   input wire logic        tx_bit_valid, // Bit strobe.
   input wire logic        rx_bit_valid, // Receive strobe.
   input wire logic        irq           // Interrupt.
);
   // Access decode shared by the properties below.
   wire acc     = psel && penable;
   wire hit     = paddr == 12'h1C4 || paddr == 12'h1C8 || paddr == 12'h1CC;
   wire stat_wr = acc && pwrite && paddr == 12'h1C8;
   wire flag_wr = acc && pwrite && paddr == 12'h1CC;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_always_a: assert property (psel |-> pready) else $error("ready low");
   unmapped_err_a: assert property (acc && !hit |-> pslverr) else $error("no error");
   mapped_ok_a: assert property (acc && hit |-> !pslverr) else $error("false error");
   tx_answer_a: assert property (tx_bit_req |=> tx_bit_valid) else $error("no tx bit");
   tx_hold_a: assert property (!tx_bit_req |=> !tx_bit_valid && $stable(tx_bit))
      else $error("tx bit moved");
   flag_bits_a: assert property (acc && !pwrite && paddr == 12'h1CC |->
      prdata[31:4] == 28'h0 && prdata[2:1] == 2'h0) else $error("stray flag bit");
   ctrl_width_a: assert property (acc && !pwrite && paddr != 12'h1CC |->
      prdata[31:4] == 28'h0) else $error("stray control bit");
   irq_rise_a: assert property ($rose(irq) |->
      $past(rx_bit_valid) || $past(stat_wr)) else $error("irq rose without cause");
   irq_sticky_a: assert property ($fell(irq) |->
      $past(stat_wr) || $past(flag_wr)) else $error("irq fell without write");
   cover property ($rose(irq));
   cover property (acc && pslverr);
   cover property (tx_bit_valid [*8]);
endmodule // pattern_gen_detector_chk

bind pattern_gen_detector pattern_gen_detector_chk i_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .tx_bit_req, .tx_bit, .tx_bit_valid,
   .rx_bit_valid, .irq);

// ===== test/framer_model.sv
`timescale 1ns/10ps
module framer_model (
   input  wire logic pclk,         // Clock.
   input  wire logic presetn,      // Reset, active low.
   input  wire logic run,          // Stream bits while high.
   input  wire logic slow,         // Request every other cycle.
   input  wire logic corrupt,      // Flip the looped bit.
   output      logic tx_bit_req,   // Takes one bit.
   input  wire logic tx_bit,       // Transmit bit.
   input  wire logic tx_bit_valid, // Transmit strobe.
   output      logic rx_bit_valid, // Receive strobe.
   output      logic rx_bit        // Receive bit.
);
   logic odd_ff; // Pacing phase.
   // Loops each sent bit back; between bits the line toggles every cycle so stale data never holds still.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odd_ff <= 1'b0;
         tx_bit_req <= 1'b0;
         rx_bit_valid <= 1'b0;
         rx_bit <= 1'b0;
      end else begin
         odd_ff <= ~odd_ff;
         tx_bit_req <= run && (!slow || odd_ff);
         rx_bit_valid <= tx_bit_valid;
         rx_bit <= tx_bit_valid ? tx_bit ^ corrupt : ~rx_bit;
      end
   end
endmodule // framer_model

// ===== test/pattern_gen_detector_bench.sv
`timescale 1ns/10ps
module pattern_gen_detector_bench;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, tx_bit_req, tx_bit, tx_bit_valid, rx_bit_valid, rx_bit, irq;
   logic        run = 1'b0, slow = 1'b0, corrupt = 1'b0;
   logic [32:0] exp_q[$], msk_q[$];
   logic [7:0]  ctl[7] = '{8'h00, 8'h01, 8'h06, 8'h0E, 8'h08, 8'h03, 8'h00};
   logic        lk[7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   int          n_mismatch = 0, cmp_count = 0;
   integer      seed = 32'had073fc3;
   always #10 pclk = ~pclk;
   pattern_gen_detector i_pattern_gen_detector (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_bit_req, .tx_bit, .tx_bit_valid,
      .rx_bit_valid, .rx_bit, .irq);
   framer_model i_framer_model (.pclk, .presetn, .run, .slow, .corrupt, .tx_bit_req, .tx_bit,
      .tx_bit_valid, .rx_bit_valid, .rx_bit);
   task automatic close_out;
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [32:0] got, input logic [32:0] want);
      cmp_count++;
      if (got !== want) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   // Entered just after a rising edge; holds the request until pready is seen high.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin n_mismatch++; close_out(); end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] x, input logic [32:0] k);
      exp_q.push_back(x & k);
      msk_q.push_back(k);
      bus(1'b0, a, 8'h00);
   endtask
   // Each completed read is matched against the oldest noted expectation.
   always @(posedge pclk) begin
      if ((psel && penable && !pwrite && pready) === 1'b1)
         cmp({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
   end
   // Main sequence; lock waits are generous because the reload needs up to 20 bits first.
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h1C4, 33'h0, '1);
      rd(12'h1C8, 33'h0, '1);
      rd(12'h1CC, 33'h0, '1);
      rd(12'h000, 33'h100000000, '1);
      run <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, 12'h1C4, ctl[i]);
         slow <= (i == 3);
         repeat (400) @(posedge pclk);
         rd(12'h1C8, {31'h0, lk[i], 1'b0}, 33'h2);
      end
      bus(1'b1, 12'h1CC, 8'h09);
      rd(12'h1CC, 33'h0, '1);
      bus(1'b1, 12'h1C8, 8'h0C);
      repeat (20) @(posedge pclk);
      rd(12'h1C8, 33'h0A, '1);
      rd(12'h1CC, 33'h08, '1);
      cmp({32'h0, irq}, 33'h1);
      bus(1'b1, 12'h1CC, 8'h00);
      rd(12'h1CC, 33'h08, '1);
      bus(1'b1, 12'h1C8, 8'h00);
      cmp({32'h0, irq}, 33'h0);
      rd(12'h1C8, 33'h02, '1);
      bus(1'b1, 12'h1CC, 8'h08);
      bus(1'b1, 12'h1C8, 8'h01);
      cmp({32'h0, irq}, 33'h0);
      repeat (200) begin corrupt <= 1'($random(seed)); @(posedge pclk); end
      corrupt <= 1'b0;
      cmp({32'h0, irq}, 33'h1);
      rd(12'h1C8, 33'h01, '1);
      rd(12'h1CC, 33'h01, 33'h1);
      bus(1'b1, 12'h1CC, 8'h09);
      cmp({32'h0, irq}, 33'h0);
      repeat (200) @(posedge pclk);
      cmp({32'h0, irq}, 33'h1);
      rd(12'h1C8, 33'h03, '1);
      close_out();
   end
endmodule // pattern_gen_detector_bench
